/* dv/clock_synth_checker.sv */
/* Port assertions for the synthesizer configuration decode.
   Assumes binding to clock_synth_config_decode, one clock, sync reset. */
`timescale 1ns/1ps
module clock_synth_checker (
  input wire       clock_in,
  input wire       rst_in,
  input wire [1:0] profile_select_in,
  input wire       reg_wr_in,
  input wire       reg_rd_in,
  input wire [4:0] reg_addr_in,
  input wire [7:0] reg_wdata_in,
  input wire [7:0] reg_rdata_out,
  input wire       reg_rvalid_out,
  input wire [2:0] input_divider_out,
  input wire [1:0] prescaler_mode_out,
  input wire [8:0] feedback_divider_out,
  input wire [1:0] loop_bandwidth_out,
  input wire       pll_skip_out,
  input wire       pll_feed_out,
  input wire [6:0] output_divider_out,
  input wire [3:0] output_drive_on_out,
  input wire [3:0] output_style_sel_out,
  input wire [1:0] active_profile_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (rst_in);
  wire [34:0] ctl_all = {active_profile_out, input_divider_out, prescaler_mode_out,
    feedback_divider_out, loop_bandwidth_out, pll_skip_out, pll_feed_out,
    output_divider_out, output_drive_on_out, output_style_sel_out};
  wire [3:0]  oe_bits = {reg_wdata_in[6], reg_wdata_in[5], reg_wdata_in[2], reg_wdata_in[1]};
  chk_read_latency: assert property (reg_rd_in |-> ##2 reg_rvalid_out)
    else $error("read answer late");
  chk_unmapped_zero: assert property (reg_rd_in && reg_addr_in > 5'h17 |-> ##2
    reg_rdata_out == 8'h00) else $error("unmapped read not zero");
  chk_idiv_codes: assert property (input_divider_out inside {3'h1, 3'h2, 3'h4, 3'h5})
    else $error("bad input divider");
  chk_fb_even: assert property (!feedback_divider_out[0])
    else $error("odd feedback divider");
  chk_fb_write: assert property (reg_wr_in && reg_addr_in[4:2] == 3'h0 &&
    reg_addr_in[1:0] == active_profile_out |-> ##2 (active_profile_out !=
    $past(active_profile_out, 2) || feedback_divider_out == {$past(reg_wdata_in, 2), 1'b0}))
    else $error("feedback write not applied");
  chk_od_even: assert property (output_divider_out > 7'h05 |-> !output_divider_out[0])
    else $error("odd large output divider");
  chk_skip_feed: assert property (!$past(rst_in) |-> pll_skip_out != pll_feed_out)
    else $error("skip and feed agree");
  chk_oe_write: assert property (reg_wr_in && reg_addr_in[4:2] == 3'h4 &&
    reg_addr_in[1:0] == active_profile_out |-> ##2 (active_profile_out !=
    $past(active_profile_out, 2) || output_drive_on_out == $past(oe_bits, 2)))
    else $error("enable write not applied");
  chk_hold_quiet: assert property ((!reg_wr_in && $stable(profile_select_in)) [*5]
    |=> $stable(ctl_all)) else $error("controls moved without cause");
  cover property (reg_rd_in ##2 reg_rvalid_out);
  cover property (pll_skip_out);
  cover property ($changed(active_profile_out));
endmodule // clock_synth_checker

bind clock_synth_config_decode clock_synth_checker chk_u (.clock_in(clock_in),
  .rst_in(rst_in), .profile_select_in(profile_select_in), .reg_wr_in(reg_wr_in),
  .reg_rd_in(reg_rd_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
  .reg_rdata_out(reg_rdata_out), .reg_rvalid_out(reg_rvalid_out),
  .input_divider_out(input_divider_out), .prescaler_mode_out(prescaler_mode_out),
  .feedback_divider_out(feedback_divider_out), .loop_bandwidth_out(loop_bandwidth_out),
  .pll_skip_out(pll_skip_out), .pll_feed_out(pll_feed_out),
  .output_divider_out(output_divider_out), .output_drive_on_out(output_drive_on_out),
  .output_style_sel_out(output_style_sel_out), .active_profile_out(active_profile_out));

/* dv/host_model.sv */
/* Configuration host: byte writes and reads on the register port.
   Assumes inputs change at the falling edge; idle lines are inverted. */
`timescale 1ns/1ps
module host_model (
  input  wire       clock_in,
  input  wire [7:0] rdata_in,
  input  wire       rvalid_in,
  output reg        req_wr_out = 1'b0,
  output reg        req_rd_out = 1'b0,
  output reg  [4:0] req_addr_out = 5'h00,
  output reg  [7:0] req_wdata_out = 8'h00
);
  task wr(input [4:0] a, input [7:0] d);
  begin
    @(negedge clock_in);
    {req_wr_out, req_addr_out, req_wdata_out} = {1'b1, a, d};
    @(negedge clock_in);
    {req_wr_out, req_addr_out, req_wdata_out} = {1'b0, ~a, ~d};
  end
  endtask
  task rd(input [4:0] a, output [7:0] d, output ok);
  begin
    ok = 1'b0;
    d = 8'h00;
    @(negedge clock_in);
    {req_rd_out, req_addr_out} = {1'b1, a};
    @(negedge clock_in);
    {req_rd_out, req_addr_out} = {1'b0, ~a};
    repeat (3) @(negedge clock_in) if (rvalid_in && !ok) {ok, d} = {1'b1, rdata_in};
  end
  endtask
endmodule // host_model

/* dv/tb_top.sv */
/* Self-checking bench of the configuration decode with a byte model.
   Assumes host_model on the register port and the checker bound. */
`timescale 1ns/1ps
module tb_top;
  reg clock_in = 1'b0;
  reg rst_in = 1'b1;
  reg [1:0] sel = 2'h0;
  wire wr, rd, rv, sk, fd;
  wire [4:0] a;
  wire [7:0] wd, rdat;
  wire [2:0] idv;
  wire [1:0] psm, cp, ap;
  wire [8:0] fb;
  wire [6:0] od;
  wire [3:0] oe, st;
  integer err_count = 0, checked = 0, i, p, m;
  reg [7:0] mem [0:23];
  reg [7:0] d;
  reg ok;
  initial forever #2 clock_in = ~clock_in;
  clock_synth_config_decode dut_u (.clock_in(clock_in), .rst_in(rst_in),
    .profile_select_in(sel), .reg_wr_in(wr), .reg_rd_in(rd), .reg_addr_in(a),
    .reg_wdata_in(wd), .reg_rdata_out(rdat), .reg_rvalid_out(rv), .input_divider_out(idv),
    .prescaler_mode_out(psm), .feedback_divider_out(fb), .loop_bandwidth_out(cp),
    .pll_skip_out(sk), .pll_feed_out(fd), .output_divider_out(od),
    .output_drive_on_out(oe), .output_style_sel_out(st), .active_profile_out(ap));
  host_model host_u (.clock_in(clock_in), .rdata_in(rdat), .rvalid_in(rv), .req_wr_out(wr),
    .req_rd_out(rd), .req_addr_out(a), .req_wdata_out(wd));
  task cmp(input [39:0] got, input [39:0] exp);
  begin
    checked = checked + 1;
    if (got !== exp)
    begin
      err_count = err_count + 1;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  end
  endtask
  function [34:0] exp_dec(input integer q);
    reg [7:0] c, n, e, s;
  begin
    {c, n, e, s} = {mem[8+q], mem[4+q], mem[16+q], mem[12+q]};
    exp_dec = {q[1:0], c[3:2] == 2'h0 ? 3'h1 : c[3:2] == 2'h1 ? 3'h2 : c[3:2] == 2'h2 ?
      3'h4 : 3'h5, c[5] ? 2'h2 : {1'b0, c[4]}, mem[q], 1'b0, c[1:0], c[6], !c[6],
      n[6:0] > 7'h05 ? {n[6:1], 1'b0} : n[6:0], e[6], e[5], e[2], e[1], s[6], s[5], s[2], s[1]};
  end
  endfunction
  task put(input [4:0] ad, input [7:0] v);
  begin
    host_u.wr(ad, v);
    if (ad < 5'h18) mem[ad] = v;
  end
  endtask
  task get(input [4:0] ad);
  begin
    host_u.rd(ad, d, ok);
    cmp({ok, d}, {1'b1, ad < 5'h18 ? mem[ad] : 8'h00});
  end
  endtask
  task test_done;
  begin
    $display("checks %0d errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  end
  endtask
  initial
  begin
    #100000;
    err_count = err_count + 1;
    test_done;
  end
  initial
  begin
    for (i = 0; i < 24; i = i + 1)
      mem[i] = i < 4 ? 8'h14 : i < 8 ? 8'h04 : i < 12 ? 8'h21 : i < 20 ? 8'h66 : 8'h00;
    d = $urandom(51);
    repeat (4) @(negedge clock_in);
    rst_in = 1'b0;
    repeat (3) @(negedge clock_in);
    cmp({ap, idv, psm, fb, cp, sk, fd, od, oe, st}, exp_dec(0));
    for (i = 0; i < 20; i = i + 1) get(i);
    put(5'h18, 8'h5a);
    get(5'h18);
    for (i = 0; i < 8; i = i + 1)
    begin
      p = i % 4;
      sel = p;
      m = i == 3 ? $urandom_range(125, 96) : $urandom_range(125, 8);
      put(p, m);
      put(4 + p, i == 0 ? 8'h07 : i == 1 ? 8'h05 : i == 2 ? 8'h02 : $urandom_range(127, 2));
      // Charge pump follows the feedback divider; prescaler codes all visited
      d = {1'b0, 1'($urandom), 2'((i + 1) % 4), 2'(i % 4),
        m < 24 ? 2'h0 : m < 50 ? 2'h1 : m < 96 ? 2'h2 : 2'h3};
      put(8 + p, d);
      put(12 + p, $urandom & 8'h7f);
      put(16 + p, $urandom & 8'h7f);
      repeat (3) @(negedge clock_in);
      cmp({ap, idv, psm, fb, cp, sk, fd, od, oe, st}, exp_dec(p));
      get(8 + p);
      get(p);
    end
    test_done;
  end
endmodule // tb_top

/* rtl/clock_synth_config_decode.v */
/*
  Configuration fields of a four-output clock synthesizer and their decode
  into PLL, divider and output buffer controls.
  Assumes a byte-wide register port fed by a serial slave on the same clock;
  the profile select pins are asynchronous and are synchronised here.
*/
`timescale 1ns/1ps
`include "clock_synth_defines.vh"

// Overview of operation
// R1: Input divider code maps to 1,2,4,5
// R2: Prescaler 00 x1, 01 x0.5, 1x x2
// R3: Feedback field holds divider bits 8..1
// R4: Host keeps feedback divider within 16..250
// R5: Output codes 2..5 decode directly
// R6: Larger output codes ignore LSB, even
// R7: Host matches charge-pump code to divider
// R8: Skip bit set routes prescaler around PLL
// R9: Skip bit clear feeds prescaler into PLL
// R10: Per-output enable, 0 high impedance
// R11: Per-output style, 1 differential low-voltage
// R12: Four profiles load defaults at power-up
// R13: Host should prefer prescaler times two
// R14: Charge-pump code sets loop bandwidth
// R15: Select pins or writes change frequency
// R16: Four frequencies, input divider in clock mode
// R17: Selected profile drives outputs, tracks changes
module clock_synth_config_decode (
  // Clock and reset
  input  wire        clock_in,
  input  wire        rst_in,
  // Profile select pins
  input  wire [1:0]  profile_select_in,
  // Register port
  input  wire        reg_wr_in,
  input  wire        reg_rd_in,
  input  wire [4:0]  reg_addr_in,
  input  wire [7:0]  reg_wdata_in,
  output reg  [7:0]  reg_rdata_out,
  output reg         reg_rvalid_out,
  // PLL controls
  output reg  [2:0]  input_divider_out,
  output reg  [1:0]  prescaler_mode_out,
  output reg  [8:0]  feedback_divider_out,
  output reg  [1:0]  loop_bandwidth_out,
  output reg         pll_skip_out,
  output reg         pll_feed_out,
  // Output divider, buffers and active profile
  output reg  [6:0]  output_divider_out,
  output reg  [3:0]  output_drive_on_out,
  output reg  [3:0]  output_style_sel_out,
  output reg  [1:0]  active_profile_out
);

  // --------------------------------------------------------------------------
  // Profile select synchroniser
  // --------------------------------------------------------------------------
  reg  [1:0]   sel_meta_r;
  reg  [1:0]   sel_sync_r;

  always @(posedge clock_in)
  begin
    if (rst_in)
    begin
      sel_meta_r <= `RST_PROFILE;
      sel_sync_r <= `RST_PROFILE;
    end
    else
    begin
      // Only the second stage feeds logic; the first may be metastable
      sel_meta_r <= profile_select_in;
      sel_sync_r <= sel_meta_r;                           // see R15
    end
  end

  // --------------------------------------------------------------------------
  // Profile store
  // --------------------------------------------------------------------------
  wire [7:0]   store_rdata;
  wire [191:0] image;
  reg          rd_pend_r;

  profile_store #(
    .DEPTH       (`STORE_DEPTH)
  ) u_store (
    .clock_in    (clock_in),
    .rst_in      (rst_in),
    .wr_en_in    (reg_wr_in),                             // see R15
    .wr_addr_in  (reg_addr_in),
    .wr_data_in  (reg_wdata_in),
    .rd_addr_in  (reg_addr_in),
    .rd_data_out (store_rdata),
    .image_out   (image)
  );

  // --------------------------------------------------------------------------
  // Read return: store data registered once more, valid two edges on
  // --------------------------------------------------------------------------
  always @(posedge clock_in)
  begin
    if (rst_in)
    begin
      rd_pend_r      <= `RST_FLAG;
      reg_rdata_out  <= `RST_BYTE;
      reg_rvalid_out <= `RST_FLAG;
    end
    else
    begin
      rd_pend_r      <= reg_rd_in;
      reg_rvalid_out <= rd_pend_r;
      if (rd_pend_r)
        reg_rdata_out <= store_rdata;
    end
  end

  // --------------------------------------------------------------------------
  // Field pick for the selected profile
  // --------------------------------------------------------------------------
  // Picked straight from the store image, so a write reaches the controls next edge
  wire [4:0] fb_idx    = `REG_FB_BASE + {3'h0, sel_sync_r};   // see R17
  wire [4:0] od_idx    = `REG_OD_BASE + {3'h0, sel_sync_r};
  wire [4:0] ctl_idx   = `REG_CTL_BASE + {3'h0, sel_sync_r};
  wire [4:0] style_idx = `REG_STYLE_BASE + {3'h0, sel_sync_r};
  wire [4:0] oe_idx    = `REG_OE_BASE + {3'h0, sel_sync_r};

  wire [7:0] fb_byte    = image[{fb_idx, 3'h0} +: 8];
  wire [7:0] od_byte    = image[{od_idx, 3'h0} +: 8];
  wire [7:0] ctl_byte   = image[{ctl_idx, 3'h0} +: 8];
  wire [7:0] style_byte = image[{style_idx, 3'h0} +: 8];
  wire [7:0] oe_byte    = image[{oe_idx, 3'h0} +: 8];

  wire [1:0] idiv_code = ctl_byte[`CTL_IDIV_HI:`CTL_IDIV_LO];
  wire [1:0] ps_code   = ctl_byte[`CTL_PS_HI:`CTL_PS_LO];
  wire       skip      = ctl_byte[`CTL_SKIP_BIT];

  // --------------------------------------------------------------------------
  // Decode
  // --------------------------------------------------------------------------
  reg  [2:0] idiv_nxt;
  reg  [1:0] ps_nxt;
  reg  [6:0] od_nxt;

  always @*
  begin
    case (idiv_code)                                      // see R1
      `IDIV_CODE_1: idiv_nxt = `IDIV_VAL_1;
      `IDIV_CODE_2: idiv_nxt = `IDIV_VAL_2;
      `IDIV_CODE_4: idiv_nxt = `IDIV_VAL_4;
      default:      idiv_nxt = `IDIV_VAL_5;
    endcase
    if (ps_code[1])                                       // see R2
      ps_nxt = `PS_MODE_X2;
    else if (ps_code == `PS_CODE_X1)
      ps_nxt = `PS_MODE_X1;
    else
      ps_nxt = `PS_MODE_HALF;
    if (od_byte[6:0] <= `OD_DIRECT_MAX)                   // see R5
      od_nxt = od_byte[6:0];
    else
      od_nxt = {od_byte[6:1], 1'b0};                      // see R6
  end

  // --------------------------------------------------------------------------
  // Control pick and output bit gather
  // --------------------------------------------------------------------------
  reg  [8:0] fb_nxt;
  reg  [1:0] cp_nxt;
  reg        skip_nxt;
  reg        feed_nxt;
  reg  [3:0] oe_nxt;
  reg  [3:0] style_nxt;

  always @*
  begin
    // The field holds bits 8..1, so bit 0 of the divider is always clear
    fb_nxt    = {fb_byte, 1'b0};                          // see R3
    cp_nxt    = ctl_byte[`CTL_CP_HI:`CTL_CP_LO];          // see R14
    // Exactly one of the two paths reaches the output divider
    skip_nxt  = skip;                                     // see R8
    feed_nxt  = ~skip;                                    // see R9
    // Output bits sit scattered in their bytes; gather them as Q3..Q0
    oe_nxt    = {oe_byte[`OUT_Q3_BIT], oe_byte[`OUT_Q2_BIT],
                 oe_byte[`OUT_Q1_BIT], oe_byte[`OUT_Q0_BIT]};             // see R10
    style_nxt = {style_byte[`OUT_Q3_BIT], style_byte[`OUT_Q2_BIT],
                 style_byte[`OUT_Q1_BIT], style_byte[`OUT_Q0_BIT]};       // see R11
  end

  // --------------------------------------------------------------------------
  // Registered controls
  // --------------------------------------------------------------------------
  always @(posedge clock_in)
  begin
    if (rst_in)
    begin
      input_divider_out    <= `IDIV_VAL_1;
      prescaler_mode_out   <= `PS_MODE_X1;
      feedback_divider_out <= `RST_FB;
      loop_bandwidth_out   <= `RST_CP;
      pll_skip_out         <= `RST_FLAG;
      pll_feed_out         <= `RST_FLAG;
      output_divider_out   <= `RST_OD;
      output_drive_on_out  <= `RST_OUT_BITS;
      output_style_sel_out <= `RST_OUT_BITS;
      active_profile_out   <= `RST_PROFILE;
    end
    else
    begin
      // Input divider applies only when the reference is a clock input
      input_divider_out    <= idiv_nxt;                   // see R16
      prescaler_mode_out   <= ps_nxt;
      feedback_divider_out <= fb_nxt;                     // see R3
      loop_bandwidth_out   <= cp_nxt;                     // see R14
      pll_skip_out         <= skip_nxt;                   // see R8
      pll_feed_out         <= feed_nxt;                   // see R9
      output_divider_out   <= od_nxt;
      output_drive_on_out  <= oe_nxt;                     // see R10
      output_style_sel_out <= style_nxt;                  // see R11
      active_profile_out   <= sel_sync_r;                 // see R17
    end
  end

endmodule // clock_synth_config_decode

/* rtl/clock_synth_defines.vh */
/*
  Constants of the clock synthesizer configuration block: register indices,
  field positions inside the configuration bytes, decode values and reset
  defaults of the four profiles.
  Assumes inclusion by bare name from files under rtl/.
*/
`ifndef CLOCK_SYNTH_DEFINES_VH
`define CLOCK_SYNTH_DEFINES_VH

// ----------------------------------------------------------------------------
// Register indices (profile n adds n to the group base)
// ----------------------------------------------------------------------------
`define REG_FB_BASE        5'h00
`define REG_OD_BASE        5'h04
`define REG_CTL_BASE       5'h08
`define REG_STYLE_BASE     5'h0c
`define REG_OE_BASE        5'h10
`define REG_LAST           5'h17
`define REG_OE_LAST        5'h13
`define STORE_DEPTH        24

// ----------------------------------------------------------------------------
// Control byte fields
// ----------------------------------------------------------------------------
`define CTL_SKIP_BIT       6
`define CTL_PS_HI          5
`define CTL_PS_LO          4
`define CTL_IDIV_HI        3
`define CTL_IDIV_LO        2
`define CTL_CP_HI          1
`define CTL_CP_LO          0

// Output bits Q0..Q3 sit at D1, D2, D5, D6 of the style and enable bytes
`define OUT_Q0_BIT         1
`define OUT_Q1_BIT         2
`define OUT_Q2_BIT         5
`define OUT_Q3_BIT         6

// ----------------------------------------------------------------------------
// Decode values
// ----------------------------------------------------------------------------
`define IDIV_CODE_1        2'h0
`define IDIV_CODE_2        2'h1
`define IDIV_CODE_4        2'h2
`define IDIV_VAL_1         3'h1
`define IDIV_VAL_2         3'h2
`define IDIV_VAL_4         3'h4
`define IDIV_VAL_5         3'h5
`define PS_CODE_X1         2'h0
`define PS_MODE_X1         2'h0
`define PS_MODE_HALF       2'h1
`define PS_MODE_X2         2'h2
`define OD_DIRECT_MAX      7'h05

// ----------------------------------------------------------------------------
// Factory defaults (one byte per register group, the same for profiles 0..3)
// ----------------------------------------------------------------------------
`define DEF_FB             8'h14
`define DEF_OD             7'h04
`define DEF_CTL            7'h21
`define DEF_STYLE          8'h66
`define DEF_OE             8'h66

// ----------------------------------------------------------------------------
// Reset values of the registered controls and the read return
// ----------------------------------------------------------------------------
`define RST_FLAG           1'b0
`define RST_BYTE           8'h00
`define RST_FB             9'h000
`define RST_CP             2'h0
`define RST_OD             7'h00
`define RST_OUT_BITS       4'h0
`define RST_PROFILE        2'h0

`endif

/* rtl/profile_store.v */
/*
  Register file of the four configuration profiles, 24 bytes deep.
  One write port and one read port; read data come out of a register.
  Assumes a single clock and a synchronous active-high reset that loads
  the factory defaults.
*/
`timescale 1ns/1ps
`include "clock_synth_defines.vh"

module profile_store #(
  parameter DEPTH = 24
) (
  // Clock and reset
  input  wire        clock_in,
  input  wire        rst_in,
  // Write port
  input  wire        wr_en_in,
  input  wire [4:0]  wr_addr_in,
  input  wire [7:0]  wr_data_in,
  // Read port
  input  wire [4:0]  rd_addr_in,
  output reg  [7:0]  rd_data_out,
  // Whole store, flat, byte i at [8*i+7:8*i]
  output wire [191:0] image_out
);

  reg [7:0] mem_r [0:DEPTH-1];
  integer   i;

  // --------------------------------------------------------------------------
  // Default image per byte
  // --------------------------------------------------------------------------
  function [7:0] default_byte;
    input [4:0] a;
    begin
      if (a < `REG_OD_BASE)
        default_byte = `DEF_FB;
      else if (a < `REG_CTL_BASE)
        default_byte = {1'b0, `DEF_OD};
      else if (a < `REG_STYLE_BASE)
        default_byte = {1'b0, `DEF_CTL};
      else if (a < `REG_OE_BASE)
        default_byte = `DEF_STYLE;
      else if (a <= `REG_OE_LAST)
        default_byte = `DEF_OE;
      else
        default_byte = 8'h00;
    end
  endfunction

  always @(posedge clock_in)
  begin
    if (rst_in)
    begin
      for (i = 0; i < DEPTH; i = i + 1)
        mem_r[i] <= default_byte(i[4:0]);                 // see R12
      rd_data_out <= `RST_BYTE;
    end
    else
    begin
      if (wr_en_in && (wr_addr_in < DEPTH))
        mem_r[wr_addr_in] <= wr_data_in;
      rd_data_out <= (rd_addr_in < DEPTH) ? mem_r[rd_addr_in] : 8'h00;
    end
  end

  genvar g;
  generate
    for (g = 0; g < DEPTH; g = g + 1)
    begin : flat
      assign image_out[8*g+7:8*g] = mem_r[g];
    end
  endgenerate

endmodule // profile_store
